// ==== logic/bcs_defines.vh ====
// constants for the bar code serial capture block
// assumes a 100 MHz system clock; included by bare name
`ifndef BCS_DEFINES_VH
`define BCS_DEFINES_VH

// serial timing, fixed format
`define BCS_CLK_HZ 100000000
`define BCS_BAUD 9600
`define BCS_DATA_BITS 4'h8
// cycles per bit, rounded down
// BCS_CLK_HZ / BCS_BAUD, sized to the 16 bit bit timer
`define BCS_BIT_CYCLES 16'h28b0

// character codes
`define BCS_CHAR_CR 8'h0d
`define BCS_CHAR_SPACE 8'h20

// destination word limits
`define BCS_WORDS_MIN 6'h02
`define BCS_WORDS_MAX 6'h20
`define BCS_BUF_DEPTH 62
`define BCS_BUF_LAST 6'h3d

// flag positions
`define BCS_AVAIL_BIT 5
`define BCS_ABORT_BIT 5
`define BCS_ACK_BIT 6
`define BCS_SYS_STATUS_OFF 5'h04
`define BCS_RELAY_AVAIL_OFF 16'h0008
`define BCS_RELAY_ABORT_OFF 16'h0009
`define BCS_RELAY_ACK_OFF 16'h000a

// register offsets (byte addresses)
`define BCS_REG_CTRL 8'h00
`define BCS_REG_WORDS 8'h04
`define BCS_REG_BASE 8'h08
`define BCS_REG_IRQ_STATUS 8'h0c
`define BCS_REG_IRQ_MASK 8'h10
`define BCS_REG_STATE 8'h14

// control fields and reset values
`define BCS_CTRL_ENABLE 0
`define BCS_CTRL_PORT_BUSY 1
`define BCS_CTRL_RELAY_MODE 2
`define BCS_CTRL_RESET 3'h0
`define BCS_BASE_RESET 16'h0000

// interrupt event bits
`define BCS_EV_STORED 0
`define BCS_EV_ERROR 1
`define BCS_EV_ABORT 2

`endif

// ==== logic/bcs_uart_rx.v ====
// fixed format serial receiver: 8 data bits, even parity, one stop bit
// assumes rx_i is an asynchronous pin idling high
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defines.vh"

module bcs_uart_rx #(
  parameter [15:0] BIT_CYCLES = `BCS_BIT_CYCLES
)(
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // serial pin
  input wire rx_i,
  // received character
  output reg [7:0] char_o,
  output reg char_valid_o,
  output reg parity_err_o,
  output reg frame_err_o
);
  // one-hot receiver states
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_START = 5'h02;
  localparam [4:0] S_DATA = 5'h04;
  localparam [4:0] S_PARITY = 5'h08;
  localparam [4:0] S_STOP = 5'h10;

  reg [2:0] sync; // three stage pin synchroniser
  reg rx_level; // accepted line level
  reg [4:0] state;
  reg [15:0] timer; // cycles left to next sample
  reg [3:0] bit_cnt; // data bits taken
  reg [7:0] shift;
  reg par_ok; // parity result held to the stop bit

  // sync chain; sync[0] only feeds sync[1]
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sync <= 3'h7;
      rx_level <= 1'b1;
    end
    else
    begin
      sync <= {sync[1:0], rx_i};
      // a change counts once stages two and three agree
      if (sync[1] == sync[2])
        rx_level <= sync[2];
    end
  end

  // bit timing and framing; samples mid bit
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state <= S_IDLE;
      timer <= 16'h0000;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      par_ok <= 1'b0;
      char_o <= 8'h00;
      char_valid_o <= 1'b0;
      parity_err_o <= 1'b0;
      frame_err_o <= 1'b0;
    end
    else
    begin
      char_valid_o <= 1'b0;
      if (timer != 16'h0000)
        timer <= timer - 16'h0001;
      case (state)
        S_IDLE:
        begin
          // falling edge starts a frame, sample at half bit
          if (!rx_level)
          begin
            state <= S_START;
            timer <= {1'b0, BIT_CYCLES[15:1]};
          end
        end
        S_START:
        begin
          if (timer == 16'h0000)
          begin
            // glitch shorter than half a bit is ignored
            state <= rx_level ? S_IDLE : S_DATA;
            // reload one short: the cycle that sees zero is part of the bit
            timer <= BIT_CYCLES - 16'h0001;
            bit_cnt <= 4'h0;
          end
        end
        S_DATA:
        begin
          if (timer == 16'h0000)
          begin
            shift <= {rx_level, shift[7:1]}; // lsb first
            bit_cnt <= bit_cnt + 4'h1;
            timer <= BIT_CYCLES - 16'h0001;
            if (bit_cnt == `BCS_DATA_BITS - 4'h1)
              state <= S_PARITY;
          end
        end
        S_PARITY:
        begin
          if (timer == 16'h0000)
          begin
            // even parity over data plus parity bit
            par_ok <= ~(^{shift, rx_level});
            timer <= BIT_CYCLES - 16'h0001;
            state <= S_STOP;
          end
        end
        S_STOP:
        begin
          if (timer == 16'h0000)
          begin
            char_o <= shift;
            char_valid_o <= 1'b1;
            parity_err_o <= ~par_ok;
            frame_err_o <= ~rx_level;
            state <= S_IDLE;
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== logic/bcs_capture.v ====
// bar code serial capture: gathers a carriage-return terminated scan and
// writes it into the controller's destination words with handshake flags.
// assumes the controller's flag inputs are asynchronous levels.
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defines.vh"

module bcs_capture #(
  parameter [15:0] BIT_CYCLES = `BCS_BIT_CYCLES
)(
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // serial reader pin
  input wire rx_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // destination word writes to the controller
  output reg dest_we_o,
  output reg [4:0] dest_addr_o,
  output reg [15:0] dest_data_o,
  // controller flags, word mapping
  input wire [15:0] sys_read_word_i,
  output reg [15:0] sys_status_word_o,
  output wire [4:0] sys_status_off_o,
  // controller flags, relay mapping
  input wire abort_relay_i,
  input wire ack_relay_i,
  output reg avail_relay_o,
  output reg [15:0] relay_avail_addr_o,
  output reg [15:0] relay_abort_addr_o,
  output reg [15:0] relay_ack_addr_o,
  // interrupt
  output wire irq_o
);
  // one-hot capture states
  localparam [4:0] C_IDLE = 5'h01; // waiting for first char
  localparam [4:0] C_RECV = 5'h02; // collecting chars
  localparam [4:0] C_SKIP = 5'h04; // dropping until next CR
  localparam [4:0] C_PEND = 5'h08; // scan held, write blocked
  localparam [4:0] C_WRITE = 5'h10; // streaming words out

  // receiver outputs
  wire [7:0] rx_char;
  wire rx_valid;
  wire rx_perr;
  wire rx_ferr;

  // registers
  reg [2:0] ctrl; // enable, port busy, relay mode
  reg [5:0] words; // destination word count
  reg [15:0] base; // relay base
  reg [2:0] irq_status; // sticky events
  reg [2:0] irq_mask;

  // capture state
  reg [4:0] state;
  reg [7:0] store [0:`BCS_BUF_DEPTH-1]; // held characters
  reg [15:0] char_cnt; // all chars of the scan, truncated included
  reg [4:0] wr_idx; // word being written
  reg avail; // data-available flag
  reg [2:0] ev; // one-cycle events

  // controller flag synchronisers, three stages each
  reg [2:0] abort_sync;
  reg [2:0] ack_sync;
  reg abort_lvl;
  reg ack_lvl;

  wire relay_mode = ctrl[`BCS_CTRL_RELAY_MODE];
  wire abort_src = relay_mode ? abort_relay_i : sys_read_word_i[`BCS_ABORT_BIT];
  wire ack_src = relay_mode ? ack_relay_i : sys_read_word_i[`BCS_ACK_BIT];
  // reader is only taken when enabled and the port is free
  wire rx_open = ctrl[`BCS_CTRL_ENABLE] & ~ctrl[`BCS_CTRL_PORT_BUSY];
  wire take = rx_valid & rx_open;
  wire bad = rx_perr | rx_ferr;
  // last data word index: configured count less the head word
  wire [5:0] words_less = words - 6'h01; // at most 31, fits five bits
  wire [4:0] last_word = words_less[4:0];
  wire blocked = abort_lvl | ack_lvl | avail;
  wire [5:0] lo_idx = {wr_idx, 1'b0} - 6'h02;
  wire [5:0] hi_idx = {wr_idx, 1'b0} - 6'h01;

  // the single serial pin of the reader port
  bcs_uart_rx #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_rx (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .rx_i(rx_i),
    .char_o(rx_char),
    .char_valid_o(rx_valid),
    .parity_err_o(rx_perr),
    .frame_err_o(rx_ferr)
  );

  // flag inputs cross in from the controller
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      abort_sync <= 3'h0;
      ack_sync <= 3'h0;
      abort_lvl <= 1'b0;
      ack_lvl <= 1'b0;
    end
    else
    begin
      abort_sync <= {abort_sync[1:0], abort_src};
      ack_sync <= {ack_sync[1:0], ack_src};
      if (abort_sync[1] == abort_sync[2])
        abort_lvl <= abort_sync[2];
      if (ack_sync[1] == ack_sync[2])
        ack_lvl <= ack_sync[2];
    end
  end

  // character store, indexed by running count
  always @(posedge clk_i)
  begin
    // chars past the store are dropped
    if ((state == C_IDLE || state == C_RECV) && take && !bad && rx_char != `BCS_CHAR_CR
        && char_cnt < `BCS_BUF_DEPTH)
      store[char_cnt[5:0]] <= rx_char;
  end

  // capture sequence
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state <= C_IDLE;
      char_cnt <= 16'h0000;
      wr_idx <= 5'h00;
      avail <= 1'b0;
      ev <= 3'h0;
      dest_we_o <= 1'b0;
      dest_addr_o <= 5'h00;
      dest_data_o <= 16'h0000;
    end
    else
    begin
      ev <= 3'h0;
      dest_we_o <= 1'b0;
      // ack releases the flag
      if (ack_lvl)
        avail <= 1'b0;
      case (state)
        C_IDLE, C_RECV:
        begin
          if (take)
          begin
            if (bad)
            begin
              // corrupted scan: drop, resync on next CR
              state <= C_SKIP;
              char_cnt <= 16'h0000;
              ev[`BCS_EV_ERROR] <= 1'b1;
            end
            else if (rx_char == `BCS_CHAR_CR)
            begin
              // end code closes the string
              state <= (state == C_RECV) ? C_PEND : C_IDLE;
            end
            else
            begin
              state <= C_RECV;
              if (char_cnt != 16'hffff)
                char_cnt <= char_cnt + 16'h0001;
            end
          end
        end
        C_SKIP:
        begin
          if (take && !bad && rx_char == `BCS_CHAR_CR)
            state <= C_IDLE;
        end
        C_PEND:
        begin
          if (abort_lvl)
          begin
            // abort after arrival clears the held scan
            state <= C_IDLE;
            char_cnt <= 16'h0000;
            ev[`BCS_EV_ABORT] <= 1'b1;
          end
          else if (!blocked)
          begin
            state <= C_WRITE;
            wr_idx <= 5'h00;
          end
        end
        C_WRITE:
        begin
          dest_we_o <= 1'b1;
          dest_addr_o <= wr_idx;
          if (wr_idx == 5'h00)
            dest_data_o <= char_cnt; // full count
          else
            // earlier char low, later high, space padded
            dest_data_o <= {({10'h000, hi_idx} < char_cnt) ? store[hi_idx] : `BCS_CHAR_SPACE,
                            ({10'h000, lo_idx} < char_cnt) ? store[lo_idx] : `BCS_CHAR_SPACE};
          // at or past the end: a count shrunk mid burst cannot run away
          if (wr_idx >= last_word)
          begin
            // flag raised once the last word goes out
            state <= C_IDLE;
            avail <= 1'b1;
            char_cnt <= 16'h0000;
            ev[`BCS_EV_STORED] <= 1'b1;
          end
          else
            wr_idx <= wr_idx + 5'h01;
        end
        default:
          state <= C_IDLE;
      endcase
    end
  end

  // flag outputs in both mappings, from flops
  assign sys_status_off_o = `BCS_SYS_STATUS_OFF;
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sys_status_word_o <= 16'h0000;
      avail_relay_o <= 1'b0;
      relay_avail_addr_o <= 16'h0000;
      relay_abort_addr_o <= 16'h0000;
      relay_ack_addr_o <= 16'h0000;
    end
    else
    begin
      sys_status_word_o <= 16'h0000;
      sys_status_word_o[`BCS_AVAIL_BIT] <= avail & ~relay_mode;
      avail_relay_o <= avail & relay_mode;
      relay_avail_addr_o <= base + `BCS_RELAY_AVAIL_OFF;
      relay_abort_addr_o <= base + `BCS_RELAY_ABORT_OFF;
      relay_ack_addr_o <= base + `BCS_RELAY_ACK_OFF;
    end
  end

  // register writes; word count clamps to its legal span
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctrl <= `BCS_CTRL_RESET;
      words <= `BCS_WORDS_MIN;
      base <= `BCS_BASE_RESET;
      irq_mask <= 3'h0;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `BCS_REG_CTRL: ctrl <= reg_wdata_i[2:0];
        `BCS_REG_WORDS:
        begin
          // hold count inside 2..32; change lands at once, even mid burst
          if (reg_wdata_i[5:0] < `BCS_WORDS_MIN || reg_wdata_i[31:6] != 26'h0)
            words <= (reg_wdata_i[31:6] != 26'h0) ? `BCS_WORDS_MAX : `BCS_WORDS_MIN;
          else if (reg_wdata_i[5:0] > `BCS_WORDS_MAX)
            words <= `BCS_WORDS_MAX;
          else
            words <= reg_wdata_i[5:0];
        end
        `BCS_REG_BASE: base <= reg_wdata_i[15:0];
        `BCS_REG_IRQ_MASK: irq_mask <= reg_wdata_i[2:0];
        default: ;
      endcase
    end
  end

  // sticky events, write one to clear; a new event wins
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      irq_status <= 3'h0;
    else if (reg_wr_i && reg_addr_i == `BCS_REG_IRQ_STATUS)
      irq_status <= (irq_status & ~reg_wdata_i[2:0]) | ev;
    else
      irq_status <= irq_status | ev;
  end

  assign irq_o = |(irq_status & irq_mask);

  // read data, one cycle after the strobe; unmapped reads zero
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      reg_rdata_o <= 32'h00000000;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `BCS_REG_CTRL: reg_rdata_o <= {29'h0, ctrl};
        `BCS_REG_WORDS: reg_rdata_o <= {26'h0, words};
        `BCS_REG_BASE: reg_rdata_o <= {16'h0, base};
        `BCS_REG_IRQ_STATUS: reg_rdata_o <= {29'h0, irq_status};
        `BCS_REG_IRQ_MASK: reg_rdata_o <= {29'h0, irq_mask};
        `BCS_REG_STATE: reg_rdata_o <= {char_cnt, 3'h0, state, 7'h0, avail};
        default: reg_rdata_o <= 32'h00000000;
      endcase
    end
    else
      reg_rdata_o <= 32'h00000000;
  end
endmodule
`default_nettype wire

// ==== tb/bcs_capture_assertions.sv ====
// checker for the bar code capture block: word bursts and handshake flags
// assumes it is bound onto the capture top; one clock, async high reset
`timescale 1ns/1ps
`default_nettype none

module bcs_capture_checker #(
  parameter [15:0] BIT_CYCLES = 16'h0010
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // register port
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // destination writes
  input wire logic dest_we_o,
  input wire logic [4:0] dest_addr_o,
  // word mapped flags
  input wire logic [15:0] sys_read_word_i,
  input wire logic [15:0] sys_status_word_o,
  input wire logic [4:0] sys_status_off_o,
  // relay mapped flags
  input wire logic ack_relay_i,
  input wire logic avail_relay_o,
  input wire logic [15:0] relay_avail_addr_o,
  input wire logic [15:0] relay_abort_addr_o,
  input wire logic [15:0] relay_ack_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // a burst always opens on the count word
  a_head_first: assert property ($rose(dest_we_o) |-> dest_addr_o == 5'h00)
    else $error("burst did not open on the count word");
  // words leave in ascending order, no gaps
  a_addr_ascends: assert property (dest_we_o && $past(dest_we_o) |-> dest_addr_o == $past(dest_addr_o) + 5'h01)
    else $error("word offsets not ascending");
  // never more than 32 words in one burst
  a_burst_capped: assert property (dest_we_o && dest_addr_o == 5'h1f |=> !dest_we_o)
    else $error("burst ran past 32 words");
  // available shows shortly after the last word
  a_avail_follows: assert property ($fell(dest_we_o) |-> ##[1:3] (sys_status_word_o[5] || avail_relay_o))
    else $error("available flag missing after burst");
  // status word sits four words above the head
  a_status_offset: assert property (sys_status_off_o == 5'h04)
    else $error("status word offset wrong");
  // held acknowledge takes available down, both mappings
  a_ack_clears: assert property (sys_read_word_i[6] [*8] |-> !sys_status_word_o[5])
    else $error("acknowledge did not clear available");
  a_relay_ack_clears: assert property (ack_relay_i [*8] |-> !avail_relay_o)
    else $error("relay acknowledge did not clear available");
  // without acknowledge or abort the flag stays up
  a_avail_holds: assert property ((!sys_read_word_i[6] && !sys_read_word_i[5]) [*8] ##1 sys_status_word_o[5]
    |=> sys_status_word_o[5])
    else $error("available dropped on its own");
  // no new burst while available or acknowledge is up
  a_avail_blocks: assert property (sys_status_word_o[5] |-> !$rose(dest_we_o))
    else $error("burst while available set");
  a_ack_blocks: assert property (sys_read_word_i[6] [*8] |-> !$rose(dest_we_o))
    else $error("burst while acknowledge held");
  // relay flags sit at base plus 8, 9 and 10
  a_relay_map: assert property (relay_avail_addr_o != 16'h0000 |->
    relay_abort_addr_o == relay_avail_addr_o + 16'h0001 && relay_ack_addr_o == relay_avail_addr_o + 16'h0002)
    else $error("relay addresses not consecutive");
  // read data only in the cycle after a read
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h00000000)
    else $error("read data outside its cycle");
endmodule
`default_nettype wire

// ==== tb/bcs_reader_model.sv ====
// reader model: sends framed characters on the serial line
// assumes the testbench clock; bit time counted in clock cycles
`timescale 1ns/1ps
`default_nettype none

module bcs_reader_model #(
  parameter int BIT_CYCLES = 16
)(
  // clock
  input wire logic clk_i,
  // serial line, idles high
  output logic rx_o
);
  initial rx_o = 1'b1;

  // start, 8 data lsb first, even parity, one stop
  task automatic send(input logic [7:0] c, input logic bad);
    logic [10:0] f;
    int b;
    f = {1'b1, (^c) ^ bad, c, 1'b0};
    for (b = 0; b < 11; b++)
    begin
      @(posedge clk_i);
      rx_o <= f[b];
      repeat (BIT_CYCLES - 1) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/bcs_capture_test.sv ====
// testbench for the bar code capture block, model queues against bursts
// assumes a short bit time so whole scans run quickly
`timescale 1ns/1ps
`default_nettype none

module bcs_capture_test;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  wire rx;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] sys_read_word_i = 16'h0000;
  logic abort_relay_i = 1'b0;
  logic ack_relay_i = 1'b0;
  wire [31:0] reg_rdata_o;
  wire dest_we_o, avail_relay_o, irq_o;
  wire [4:0] dest_addr_o, status_off;
  wire [15:0] dest_data_o, sys_status_word_o, av_addr, ab_addr, ak_addr;
  int errors = 0;
  int num_checks = 0;
  int words = 2;
  logic [20:0] got_q[$], exp_q[$];
  logic [7:0] sent[$];

  always #5 clk_i = ~clk_i;

  bcs_reader_model #(.BIT_CYCLES(16)) rdr (.clk_i(clk_i), .rx_o(rx));

  bcs_capture #(.BIT_CYCLES(16'h0010)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .rx_i(rx),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .dest_we_o(dest_we_o), .dest_addr_o(dest_addr_o), .dest_data_o(dest_data_o),
    .sys_read_word_i(sys_read_word_i), .sys_status_word_o(sys_status_word_o),
    .sys_status_off_o(status_off), .abort_relay_i(abort_relay_i),
    .ack_relay_i(ack_relay_i), .avail_relay_o(avail_relay_o),
    .relay_avail_addr_o(av_addr), .relay_abort_addr_o(ab_addr),
    .relay_ack_addr_o(ak_addr), .irq_o(irq_o));

  // every word the block writes lands in the queue
  always @(posedge clk_i)
    if (dest_we_o === 1'b1)
      got_q.push_back({dest_addr_o, dest_data_o});

  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // burst contents and length against the model queue
  task automatic cmp_words;
    cmp_val(32'(got_q.size()), 32'(exp_q.size()));
    foreach (exp_q[k])
      if (k < got_q.size())
        cmp_val(32'(got_q[k]), 32'(exp_q[k]));
    got_q.delete();
    exp_q.delete();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    d = reg_rdata_o;
  endtask

  // abort bit 5, acknowledge bit 6 of the head read word
  task automatic flags(input logic ab, input logic ak);
    @(posedge clk_i);
    sys_read_word_i <= {9'h000, ak, ab, 5'h00};
    repeat (10) @(posedge clk_i);
  endtask

  function automatic logic [7:0] pick(input int i);
    return (i < sent.size()) ? sent[i] : 8'h20;
  endfunction

  // random digits then carriage return; model words if it should land
  task automatic scan(input int n, input bit bad, input bit keep);
    int k;
    sent.delete();
    for (k = 0; k < n; k++)
      sent.push_back(8'h30 + 8'($urandom % 10));
    if (keep)
    begin
      exp_q.push_back({5'h00, 16'(n)});
      for (k = 1; k < words; k++)
        exp_q.push_back({5'(k), pick(2 * k - 1), pick(2 * k - 2)});
    end
    foreach (sent[k])
      rdr.send(sent[k], bad && k == 0);
    rdr.send(8'h0d, 1'b0);
    for (k = 0; k < 40 && !(keep && got_q.size() == exp_q.size()); k++)
      @(posedge clk_i);
    repeat (6) @(posedge clk_i);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    logic [31:0] d;
    int i;
    void'($urandom(32'h2d8b));
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(8'h04, d); cmp_val(d, 32'h2);
    rd(8'h00, d); cmp_val(d, 32'h0);
    rd(8'h40, d); cmp_val(d, 32'h0);
    wr(8'h04, 32'h1); rd(8'h04, d); cmp_val(d, 32'h2);
    scan(2, 0, 0); cmp_words;
    wr(8'h00, 32'h1);
    wr(8'h10, 32'h7);
    for (i = 0; i < 3; i++)
    begin
      words = (i == 2) ? 32 : 2 + i;
      wr(8'h04, 32'(words));
      scan(1 + $urandom % 6, 0, 1); cmp_words;
      cmp_val(32'(sys_status_word_o), 32'h20);
      cmp_val(32'(irq_o), 32'h1);
      flags(0, 1); cmp_val(32'(sys_status_word_o), 32'h0);
      flags(0, 0);
      wr(8'h0c, 32'h1); cmp_val(32'(irq_o), 32'h0);
    end
    // pending scan held back, then thrown away by abort
    words = 2;
    wr(8'h04, 32'h2);
    scan(3, 0, 1); cmp_words;
    scan(2, 0, 0); cmp_words;
    flags(1, 0); rd(8'h0c, d); cmp_val(d & 32'h4, 32'h4);
    flags(0, 1); flags(0, 0); repeat (20) @(posedge clk_i); cmp_words;
    flags(1, 0); scan(2, 0, 0); cmp_words;
    flags(0, 0); wr(8'h0c, 32'h7);
    // bad parity drops a scan, the next one lands
    scan(3, 1, 0); cmp_words;
    rd(8'h0c, d); cmp_val(d & 32'h2, 32'h2);
    scan(2, 0, 1); cmp_words;
    flags(0, 1); flags(0, 0); wr(8'h0c, 32'h7);
    // relay mapping
    wr(8'h08, 32'h1230); wr(8'h00, 32'h5);
    cmp_val({ab_addr, av_addr}, 32'h12391238);
    cmp_val(32'(ak_addr), 32'h123a);
    scan(4, 0, 1); cmp_words;
    cmp_val({avail_relay_o, sys_status_word_o}, 32'h10000);
    ack_relay_i <= 1'b1; repeat (10) @(posedge clk_i);
    cmp_val(32'(avail_relay_o), 32'h0);
    ack_relay_i <= 1'b0; abort_relay_i <= 1'b1;
    scan(2, 0, 0); cmp_words;
    abort_relay_i <= 1'b0;
    // port taken for other traffic
    wr(8'h00, 32'h3);
    scan(2, 0, 0); cmp_words;
    // state word: idle, flag down, no characters held
    rd(8'h14, d);
    cmp_val(d, 32'h00000100);
    print_verdict();
  end

  // watchdog against a hung run
  initial
  begin
    // about five times the expected length of all scans
    repeat (40000) @(posedge clk_i);
    errors++;
    print_verdict();
  end
endmodule

bind bcs_capture bcs_capture_checker #(.BIT_CYCLES(BIT_CYCLES)) chk (
  .clk_i(clk_i), .reset_i(reset_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .dest_we_o(dest_we_o), .dest_addr_o(dest_addr_o), .sys_read_word_i(sys_read_word_i),
  .sys_status_word_o(sys_status_word_o), .sys_status_off_o(sys_status_off_o),
  .ack_relay_i(ack_relay_i), .avail_relay_o(avail_relay_o),
  .relay_avail_addr_o(relay_avail_addr_o), .relay_abort_addr_o(relay_abort_addr_o),
  .relay_ack_addr_o(relay_ack_addr_o));
`default_nettype wire
